// ==== rtl/screen_ctrl.sv ====
// Emitter and receiver control of a two-part optical safety screen, with an APB register slave.
// Assumes synchronous inputs on clk_sys, a synchronous active-high reset and an APB master on the bus.
//
// How it works
// - Trip mode: outputs on after power-up once self-test passed and beam clear.
// - Trip mode: outputs return on by themselves when every interruption has cleared.
// - Latch mode: outputs stay off after power-up until a manual reset.
// - Trip or latch setting decides automatic run entry or waiting for reset.
// - External device check is off, one-channel or two-channel, watching the switched devices.
// - Opening the remote test contact stops emission, acting like a beam interruption.
// - Receiver accepts only a beam whose scan code matches its own.
// - Emitter bi-colour indicator shows power, run, test and lockout.
// - Beam indicator shows strong clear, weak clear, and blocked.
// - Yellow reset indicator shows run mode or waiting for reset.
// - Receiver status indicator shows outputs on, off, and lockout distinctly.
// - Emitter and receiver drive seven-segment codes for errors and configuration.
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps
`include "screen_map.svh"
module screen_ctrl #(
  parameter int EDM_WINDOW_CYCLES = (`EDM_WINDOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int FILTER_CYCLES     = 4,
  parameter int BLINK_W           = 22
) (
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  input  wire screen_pkg::apb_req_type apb_req,
  output screen_pkg::apb_rsp_type    apb_rsp,
  output logic                       irq,
  input  wire logic                  test_contact_closed,
  input  wire logic                  emitter_fault,
  output logic                       emitter_on,
  output logic                       emitter_code,
  output screen_pkg::bicolor_type    emitter_led,
  output logic [6:0]                 emitter_seg,
  input  wire logic                  beam_seen,
  input  wire logic                  beam_code,
  input  wire logic                  beam_strong,
  input  wire logic                  self_test_ok,
  input  wire logic                  manual_reset,
  input  wire logic [1:0]            external_device_check,
  output logic [1:0]                 safety_switching_outputs,
  output screen_pkg::bicolor_type    beam_led,
  output logic                       reset_led,
  output screen_pkg::bicolor_type    status_led,
  output logic [6:0]                 receiver_seg
);

  localparam int EW = $clog2(EDM_WINDOW_CYCLES + 1);

  // ***************************************************************
  // Declarations
  // ***************************************************************
  screen_pkg::ctrl_type      ctrl_reg;
  screen_pkg::ctrl_type      ctrl_next;
  logic [`IRQ_W-1:0]         irq_status_reg;
  logic [`IRQ_W-1:0]         irq_status_next;
  logic [`IRQ_W-1:0]         irq_mask_reg;
  logic [`IRQ_W-1:0]         irq_mask_next;
  logic [31:0]               prdata_reg;
  logic [31:0]               prdata_next;
  logic [31:0]               read_word;
  logic                      mapped;
  logic                      wr_strobe;
  screen_pkg::rx_state_type  state_reg;
  screen_pkg::rx_state_type  state_next;
  logic                      outputs_on_reg;
  logic                      outputs_on_next;
  logic                      lock_edm_reg;
  logic                      lock_edm_next;
  logic                      reset_prev_reg;
  logic [EW-1:0]             edm_cnt_reg;
  logic [EW-1:0]             edm_cnt_next;
  logic [BLINK_W-1:0]        blink_reg;
  logic                      reset_press;
  logic                      edm_mismatch;
  logic                      edm_fault;
  logic                      beam_clear;
  logic                      signal_strong;
  logic [`IRQ_W-1:0]         events;
  logic                      blink;
  logic                      tx_on_reg;
  logic                      tx_on_next;
  screen_pkg::bicolor_type   tx_led_next;
  screen_pkg::bicolor_type   beam_led_next;
  screen_pkg::bicolor_type   status_led_next;
  logic                      reset_led_next;
  logic [6:0]                tx_seg_next;
  logic [6:0]                rx_seg_next;

  // ***************************************************************
  // APB slave, zero wait states
  // ***************************************************************
  assign wr_strobe = apb_req.psel && apb_req.penable && apb_req.pwrite;

  always_comb begin
    mapped    = 1'b1;
    read_word = '0;
    case (apb_req.paddr)
      `ADDR_CTRL:       read_word = {{(32-`CTRL_W){1'b0}}, ctrl_reg};
      `ADDR_STATUS:     read_word = {{`STATUS_PAD_W{1'b0}}, tx_on_reg, signal_strong, beam_clear,
                                     outputs_on_reg, state_reg};
      `ADDR_IRQ_STATUS: read_word = {{(32-`IRQ_W){1'b0}}, irq_status_reg};
      `ADDR_IRQ_MASK:   read_word = {{(32-`IRQ_W){1'b0}}, irq_mask_reg};
      default:          mapped    = 1'b0;
    endcase
  end

  // Read data is captured in the setup cycle so that it comes from a flip-flop in the access cycle.
  always_comb begin
    ctrl_next     = ctrl_reg;
    irq_mask_next = irq_mask_reg;
    prdata_next   = prdata_reg;
    if (apb_req.psel && !apb_req.penable) begin
      prdata_next = read_word;
    end
    if (wr_strobe && apb_req.paddr == `ADDR_CTRL) begin
      ctrl_next = screen_pkg::ctrl_type'(apb_req.pwdata[`CTRL_W-1:0]);
    end
    if (wr_strobe && apb_req.paddr == `ADDR_IRQ_MASK) begin
      irq_mask_next = apb_req.pwdata[`IRQ_W-1:0];
    end
    // A new event wins over a write-one-to-clear in the same cycle.
    irq_status_next = irq_status_reg;
    if (wr_strobe && apb_req.paddr == `ADDR_IRQ_STATUS) begin
      irq_status_next = irq_status_reg & ~apb_req.pwdata[`IRQ_W-1:0];
    end
    irq_status_next = irq_status_next | events;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_reg       <= screen_pkg::ctrl_type'(`CTRL_RESET);
      irq_status_reg <= '0;
      irq_mask_reg   <= '0;
      prdata_reg     <= '0;
    end else begin
      ctrl_reg       <= ctrl_next;
      irq_status_reg <= irq_status_next;
      irq_mask_reg   <= irq_mask_next;
      prdata_reg     <= prdata_next;
    end
  end

  assign apb_rsp.prdata  = prdata_reg;
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && !mapped;
  assign irq             = |(irq_status_reg & irq_mask_reg);

  // ***************************************************************
  // Beam qualification and external device check
  // ***************************************************************
  beam_qualifier #(
    .FILTER_CYCLES (FILTER_CYCLES)
  ) u_beam (
    .clk_sys       (clk_sys),
    .rst           (rst),
    .beam_seen     (beam_seen),
    .beam_code     (beam_code),
    .expect_code   (ctrl_reg.rx_code),
    .beam_strong   (beam_strong),
    .beam_clear    (beam_clear),
    .signal_strong (signal_strong)
  );

  // A de-energised device closes its feedback contact, so feedback must read the inverse of the outputs.
  always_comb begin
    case (ctrl_reg.edm_mode)
      `EDM_ONE: edm_mismatch = external_device_check[0] == outputs_on_reg;
      `EDM_TWO: edm_mismatch = |(external_device_check ^ {2{~outputs_on_reg}});
      default:  edm_mismatch = 1'b0;
    endcase
    edm_cnt_next = '0;
    if (edm_mismatch) begin
      edm_cnt_next = edm_fault ? edm_cnt_reg : edm_cnt_reg + EW'(1);
    end
  end

  assign edm_fault   = (edm_cnt_reg == EW'(EDM_WINDOW_CYCLES));
  assign reset_press = manual_reset && !reset_prev_reg;

  // ***************************************************************
  // Receiver run state
  // ***************************************************************
  always_comb begin
    state_next    = state_reg;
    lock_edm_next = lock_edm_reg;
    case (state_reg)
      screen_pkg::ST_SELFTEST: begin
        if (self_test_ok && beam_clear) begin
          state_next = ctrl_reg.latch ? screen_pkg::ST_WAIT_RESET : screen_pkg::ST_RUN;
        end
      end
      screen_pkg::ST_WAIT_RESET: begin
        if (beam_clear && reset_press) begin
          state_next = screen_pkg::ST_RUN;
        end
      end
      screen_pkg::ST_RUN: begin
        if (!beam_clear) begin
          state_next = ctrl_reg.latch ? screen_pkg::ST_WAIT_RESET : screen_pkg::ST_BLOCKED;
        end
      end
      screen_pkg::ST_BLOCKED: begin
        if (ctrl_reg.latch) begin
          state_next = screen_pkg::ST_WAIT_RESET;
        end else if (beam_clear) begin
          state_next = screen_pkg::ST_RUN;
        end
      end
      screen_pkg::ST_LOCKOUT: begin
        if (reset_press && self_test_ok && !edm_mismatch) begin
          state_next = screen_pkg::ST_SELFTEST;
        end
      end
      default: state_next = screen_pkg::ST_SELFTEST;
    endcase
    // Faults override every other move.
    if (state_reg != screen_pkg::ST_LOCKOUT &&
        (edm_fault || (!self_test_ok && state_reg != screen_pkg::ST_SELFTEST))) begin
      state_next    = screen_pkg::ST_LOCKOUT;
      lock_edm_next = edm_fault;
    end
    outputs_on_next = (state_next == screen_pkg::ST_RUN);
    events = '0;
    events[`IRQ_TRIP] = outputs_on_reg && !outputs_on_next;
    events[`IRQ_LOCK] = state_reg != screen_pkg::ST_LOCKOUT && state_next == screen_pkg::ST_LOCKOUT;
    events[`IRQ_RUN]  = !outputs_on_reg && outputs_on_next;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg      <= screen_pkg::ST_SELFTEST;
      outputs_on_reg <= 1'b0;
      lock_edm_reg   <= 1'b0;
      reset_prev_reg <= 1'b0;
      edm_cnt_reg    <= '0;
    end else begin
      state_reg      <= state_next;
      outputs_on_reg <= outputs_on_next;
      lock_edm_reg   <= lock_edm_next;
      reset_prev_reg <= manual_reset;
      edm_cnt_reg    <= edm_cnt_next;
    end
  end

  assign safety_switching_outputs = {2{outputs_on_reg}};

  // ***************************************************************
  // Emitter drive and indicators
  // ***************************************************************
  assign blink = blink_reg[BLINK_W-1];

  always_comb begin
    tx_on_next = test_contact_closed && !emitter_fault;
    tx_led_next.green = !emitter_fault && test_contact_closed;
    tx_led_next.red   = emitter_fault ? blink : !test_contact_closed;
    tx_seg_next = ctrl_reg.tx_code ? `SEG_CODE2 : `SEG_CODE1;
    if (emitter_fault) begin
      tx_seg_next = `SEG_ERR;
    end else if (!test_contact_closed) begin
      tx_seg_next = `SEG_TEST;
    end
    beam_led_next.green = beam_clear && (signal_strong || blink);
    beam_led_next.red   = !beam_clear;
    reset_led_next = (state_reg == screen_pkg::ST_RUN) ||
                     (state_reg == screen_pkg::ST_WAIT_RESET && blink);
    status_led_next.green = outputs_on_reg;
    status_led_next.red   = (state_reg == screen_pkg::ST_LOCKOUT) ? blink : !outputs_on_reg;
    rx_seg_next = ctrl_reg.rx_code ? `SEG_CODE2 : `SEG_CODE1;
    if (state_reg == screen_pkg::ST_LOCKOUT) begin
      rx_seg_next = lock_edm_reg ? `SEG_EDM : `SEG_ERR;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      blink_reg    <= '0;
      tx_on_reg    <= 1'b0;
      emitter_code <= 1'b0;
      emitter_led  <= '0;
      emitter_seg  <= '0;
      beam_led     <= '0;
      reset_led    <= 1'b0;
      status_led   <= '0;
      receiver_seg <= '0;
    end else begin
      blink_reg    <= blink_reg + BLINK_W'(1);
      tx_on_reg    <= tx_on_next;
      emitter_code <= ctrl_reg.tx_code;
      emitter_led  <= tx_led_next;
      emitter_seg  <= tx_seg_next;
      beam_led     <= beam_led_next;
      reset_led    <= reset_led_next;
      status_led   <= status_led_next;
      receiver_seg <= rx_seg_next;
    end
  end

  assign emitter_on = tx_on_reg;

  // ***************************************************************
  // Assertions
  // ***************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_trip_start;
    state_reg == screen_pkg::ST_SELFTEST && self_test_ok && beam_clear && !ctrl_reg.latch && !edm_fault
      |=> state_reg == screen_pkg::ST_RUN && safety_switching_outputs == 2'h3;
  endproperty
  a_trip_start: assert property (p_trip_start) else $error("trip start did not reach run");

  property p_trip_recover;
    state_reg == screen_pkg::ST_BLOCKED && beam_clear && !ctrl_reg.latch && !edm_fault && self_test_ok
      |=> outputs_on_reg;
  endproperty
  a_trip_recover: assert property (p_trip_recover) else $error("trip did not recover");

  property p_latch_hold;
    ctrl_reg.latch && !outputs_on_reg && !reset_press |=> !outputs_on_reg;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch mode ran without reset");

  property p_mode_entry;
    state_reg == screen_pkg::ST_SELFTEST && self_test_ok && beam_clear && ctrl_reg.latch && !edm_fault
      |=> state_reg == screen_pkg::ST_WAIT_RESET;
  endproperty
  a_mode_entry: assert property (p_mode_entry) else $error("latch mode skipped reset wait");

  property p_edm_lock;
    edm_fault && state_reg != screen_pkg::ST_LOCKOUT |=> state_reg == screen_pkg::ST_LOCKOUT && !outputs_on_reg;
  endproperty
  a_edm_lock: assert property (p_edm_lock) else $error("device check fault not locked out");

  property p_test_stop;
    !test_contact_closed |=> !emitter_on;
  endproperty
  a_test_stop: assert property (p_test_stop) else $error("emitter on with test contact open");

  property p_scan_code;
    beam_seen && beam_code != ctrl_reg.rx_code |=> !beam_clear;
  endproperty
  a_scan_code: assert property (p_scan_code) else $error("foreign scan code accepted");

  property p_reset_led;
    state_reg == screen_pkg::ST_RUN |=> reset_led;
  endproperty
  a_reset_led: assert property (p_reset_led) else $error("reset indicator dark in run");

  property p_status_led;
    outputs_on_reg |=> status_led.green && !status_led.red;
  endproperty
  a_status_led: assert property (p_status_led) else $error("status indicator wrong");

  property p_lock_hold;
    state_reg == screen_pkg::ST_LOCKOUT && !reset_press |=> state_reg == screen_pkg::ST_LOCKOUT && !outputs_on_reg;
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lockout left without reset");

endmodule : screen_ctrl

// ==== rtl/screen_map.svh ====
// Register offsets, field positions, encodings and timing figures of the safety screen controller.
// Assumes it is included by bare name from the files that need it.
`ifndef SCREEN_MAP_SVH
`define SCREEN_MAP_SVH

// ***************************************************************
// Register byte addresses
// ***************************************************************
`define ADDR_CTRL       8'h00
`define ADDR_STATUS     8'h04
`define ADDR_IRQ_STATUS 8'h08
`define ADDR_IRQ_MASK   8'h0C

// ***************************************************************
// Field layout and reset values
// ***************************************************************
`define CTRL_W          5
`define CTRL_RESET      5'h00
`define STATUS_PAD_W    25
`define IRQ_W           3
`define IRQ_TRIP        0
`define IRQ_LOCK        1
`define IRQ_RUN         2
`define EDM_OFF         2'h0
`define EDM_ONE         2'h1
`define EDM_TWO         2'h2

// ***************************************************************
// Timing
// ***************************************************************
`define CLK_PERIOD_NS   25
`define EDM_WINDOW_NS   250000

// ***************************************************************
// Seven-segment patterns, segment g in the top bit
// ***************************************************************
`define SEG_CODE1       7'h06
`define SEG_CODE2       7'h5B
`define SEG_ERR         7'h79
`define SEG_EDM         7'h5E
`define SEG_TEST        7'h78

`endif

// ==== rtl/screen_pkg.sv ====
// Types shared by the safety screen controller and its self-checking bench.
// Assumes nothing of its surroundings.
package screen_pkg;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_type;

  typedef struct packed {
    logic       latch;
    logic [1:0] edm_mode;
    logic       rx_code;
    logic       tx_code;
  } ctrl_type;

  typedef struct packed {
    logic green;
    logic red;
  } bicolor_type;

  typedef enum logic [2:0] {
    ST_SELFTEST,
    ST_WAIT_RESET,
    ST_RUN,
    ST_BLOCKED,
    ST_LOCKOUT
  } rx_state_type;

endpackage : screen_pkg

// ==== rtl/beam_qualifier.sv ====
// Beam qualifier: accepts the received beam only with a matching scan code, held for a run of samples.
// Assumes the optical front end delivers beam_seen, beam_code and beam_strong synchronous to clk_sys.
`timescale 1ns/100ps
module beam_qualifier #(
  parameter int FILTER_CYCLES = 4
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic beam_seen,
  input  wire logic beam_code,
  input  wire logic expect_code,
  input  wire logic beam_strong,
  output logic      beam_clear,
  output logic      signal_strong
);

  localparam int CW = $clog2(FILTER_CYCLES + 1);

  logic [CW-1:0] run_reg;
  logic [CW-1:0] run_next;
  logic          clear_reg;
  logic          clear_next;
  logic          strong_reg;
  logic          strong_next;
  logic          good;

  // A beam with a foreign scan code counts as no beam at all.
  assign good = beam_seen && (beam_code == expect_code);

  // Loss drops the clear flag at once; only the return is filtered, so a glitch never shortens a stop.
  always_comb begin
    run_next    = '0;
    clear_next  = 1'b0;
    strong_next = 1'b0;
    if (good) begin
      run_next = (run_reg == CW'(FILTER_CYCLES)) ? run_reg : run_reg + CW'(1);
      clear_next  = (run_next == CW'(FILTER_CYCLES));
      strong_next = clear_next && beam_strong;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      run_reg    <= '0;
      clear_reg  <= 1'b0;
      strong_reg <= 1'b0;
    end else begin
      run_reg    <= run_next;
      clear_reg  <= clear_next;
      strong_reg <= strong_next;
    end
  end

  assign beam_clear    = clear_reg;
  assign signal_strong = strong_reg;

endmodule : beam_qualifier

// ==== verif/machine_control_model.sv ====
// Behavioural model of the machine control and the devices that the safety outputs switch.
// Assumes the safety outputs, the start button and the fault command are synchronous to clk_sys.
`timescale 1ns/100ps
module machine_control_model (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic [1:0] safety_switching_outputs,
  input  wire logic       start_request,
  input  wire logic       stick_fault,
  output logic [1:0]      external_device_check,
  output logic            motion
);
  logic start_q;

  // ***************************************************************
  // Contactor feedback and motion start
  // ***************************************************************
  // A welded contact freezes the feedback, which is the fault the device check has to catch.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      external_device_check <= 2'h3;
      motion                <= 1'b0;
      start_q               <= 1'b0;
    end else begin
      start_q <= start_request;
      if (!stick_fault) external_device_check <= ~safety_switching_outputs;
      if (safety_switching_outputs != 2'h3) motion <= 1'b0;
      else if (start_request && !start_q) motion <= 1'b1;
    end
  end
endmodule : machine_control_model

// ==== verif/safety_screen_output_control_bench.sv ====
// Self-checking bench of the safety screen controller, driven over APB and its sensor pins.
// Assumes the design files and screen_map.svh are compiled first.
`timescale 1ns/100ps
`include "screen_map.svh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
module safety_screen_output_control_bench;
  logic                    clk_sys, rst, test_contact_closed, emitter_fault, emitter_on, emitter_code;
  logic                    beam_strong, self_test_ok, manual_reset, irq, reset_led, path_clear;
  logic                    start_request, stick_fault, motion, err;
  logic [1:0]              external_device_check, safety_switching_outputs, seen;
  logic [6:0]              emitter_seg, receiver_seg;
  logic [31:0]             rd;
  screen_pkg::apb_req_type apb_req;
  screen_pkg::apb_rsp_type apb_rsp;
  screen_pkg::bicolor_type emitter_led, beam_led, status_led;
  int                      n_errors, comparisons;

  screen_ctrl #(.EDM_WINDOW_CYCLES(8), .FILTER_CYCLES(2), .BLINK_W(3)) uut (
    .clk_sys(clk_sys), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp), .irq(irq),
    .test_contact_closed(test_contact_closed), .emitter_fault(emitter_fault), .emitter_on(emitter_on),
    .emitter_code(emitter_code), .emitter_led(emitter_led), .emitter_seg(emitter_seg),
    .beam_seen(emitter_on & path_clear), .beam_code(emitter_code), .beam_strong(beam_strong),
    .self_test_ok(self_test_ok), .manual_reset(manual_reset), .external_device_check(external_device_check),
    .safety_switching_outputs(safety_switching_outputs), .beam_led(beam_led), .reset_led(reset_led),
    .status_led(status_led), .receiver_seg(receiver_seg));

  machine_control_model partner (
    .clk_sys(clk_sys), .rst(rst), .safety_switching_outputs(safety_switching_outputs),
    .start_request(start_request), .stick_fault(stick_fault),
    .external_device_check(external_device_check), .motion(motion));

  // ***************************************************************
  // Bus, pin and closing tasks
  // ***************************************************************
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_sys);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge clk_sys);
    apb_req.penable <= 1'b1;
    // Only the watchdog ends a wait for the slave.
    do begin
      @(posedge clk_sys);
    end while (apb_rsp.pready !== 1'b1);
    rd  = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask : apb

  task wait_out(input logic [1:0] e, input int lim);
    int n;
    n = 0;
    while (safety_switching_outputs !== e && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
    `CHK(safety_switching_outputs, e)
  endtask : wait_out

  // A press needs a sampled low before the high, so the button is held for two edges.
  task press();
    @(posedge clk_sys);
    manual_reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    manual_reset <= 1'b0;
  endtask : press

  task final_report();
    if (n_errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    final_report();
  end

  // ***************************************************************
  // Test sequence
  // ***************************************************************
  initial begin
    n_errors = 0;
    comparisons = 0;
    apb_req = '0;
    {rst, test_contact_closed, beam_strong, self_test_ok, path_clear} = 5'h1F;
    {emitter_fault, manual_reset, start_request, stick_fault} = 4'h0;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    apb(1'b0, `ADDR_CTRL, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, 8'h10, 32'h0);
    `CHK({err, rd}, 33'h100000000)
    wait_out(2'h3, 40);
    apb(1'b0, `ADDR_STATUS, 32'h0);
    `CHK(rd[2:0], 3'h2)
    `CHK(motion, 1'b0)
    start_request <= 1'b1;
    repeat (2) @(posedge clk_sys);
    start_request <= 1'b0;
    `CHK(motion, 1'b1)
    `CHK({reset_led, status_led}, 3'h6)
    `CHK({beam_led, emitter_led, emitter_seg}, {4'hA, `SEG_CODE1})
    apb(1'b1, `ADDR_IRQ_STATUS, 32'h7);
    apb(1'b1, `ADDR_IRQ_MASK, 32'h1);
    @(posedge clk_sys);
    `CHK(irq, 1'b0)
    path_clear <= 1'b0;
    wait_out(2'h0, 10);
    repeat (3) @(posedge clk_sys);
    `CHK({irq, status_led, beam_led}, 5'h15)
    apb(1'b0, `ADDR_STATUS, 32'h0);
    `CHK(rd[2:0], 3'h3)
    apb(1'b1, `ADDR_IRQ_MASK, 32'h0);
    @(posedge clk_sys);
    `CHK(irq, 1'b0)
    apb(1'b1, `ADDR_IRQ_MASK, 32'h1);
    @(posedge clk_sys);
    `CHK(irq, 1'b1)
    apb(1'b1, `ADDR_IRQ_STATUS, 32'h1);
    @(posedge clk_sys);
    `CHK(irq, 1'b0)
    path_clear <= 1'b1;
    wait_out(2'h3, 20);
    test_contact_closed <= 1'b0;
    wait_out(2'h0, 20);
    repeat (3) @(posedge clk_sys);
    `CHK({emitter_on, emitter_led, emitter_seg}, {3'h1, `SEG_TEST})
    test_contact_closed <= 1'b1;
    wait_out(2'h3, 20);
    apb(1'b1, `ADDR_CTRL, 32'h1);
    wait_out(2'h0, 20);
    `CHK(emitter_code, 1'b1)
    apb(1'b1, `ADDR_CTRL, 32'h3);
    wait_out(2'h3, 20);
    repeat (3) @(posedge clk_sys);
    `CHK(receiver_seg, `SEG_CODE2)
    rst <= 1'b1;
    path_clear <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    apb(1'b1, `ADDR_CTRL, 32'h10);
    path_clear <= 1'b1;
    repeat (12) @(posedge clk_sys);
    `CHK(safety_switching_outputs, 2'h0)
    apb(1'b0, `ADDR_STATUS, 32'h0);
    `CHK(rd[2:0], 3'h1)
    press();
    wait_out(2'h3, 10);
    for (int m = 0; m < 3; m++) begin
      apb(1'b1, `ADDR_CTRL, {27'h0, 1'b1, m[1:0], 2'h0});
      stick_fault <= 1'b1;
      path_clear <= 1'b0;
      repeat (20) @(posedge clk_sys);
      apb(1'b0, `ADDR_STATUS, 32'h0);
      `CHK(rd[2:0], (m == 0) ? 3'h1 : 3'h4)
      path_clear <= 1'b1;
      repeat (6) @(posedge clk_sys);
      `CHK(safety_switching_outputs, 2'h0)
      if (m != 0) `CHK({status_led.green, receiver_seg}, {1'b0, `SEG_EDM})
      stick_fault <= 1'b0;
      press();
      repeat (8) @(posedge clk_sys);
      if (m != 0) press();
      wait_out(2'h3, 20);
    end
    // A weak signal makes the beam indicator blink green; eight samples span one blink period.
    beam_strong <= 1'b0;
    repeat (3) @(posedge clk_sys);
    seen = 2'h0;
    repeat (8) begin
      @(posedge clk_sys);
      seen = seen | {beam_led.green, !beam_led.green};
    end
    `CHK({seen, beam_led.red}, 3'h6)
    emitter_fault <= 1'b1;
    repeat (3) @(posedge clk_sys);
    `CHK({emitter_on, emitter_led.green, emitter_seg}, {2'h0, `SEG_ERR})
    self_test_ok <= 1'b0;
    repeat (3) @(posedge clk_sys);
    `CHK({safety_switching_outputs, receiver_seg}, {2'h0, `SEG_ERR})
    apb(1'b0, `ADDR_STATUS, 32'h0);
    `CHK(rd[2:0], 3'h4)
    final_report();
  end
endmodule : safety_screen_output_control_bench
